// File: hdl/reg_move_map.svh
// Constants for the register-based move command decoder
`ifndef REG_MOVE_MAP_SVH
`define REG_MOVE_MAP_SVH
`define CMD_REG_ABS_TIME   8'hB2
`define CMD_REG_ABS_VEL    8'hA0
`define CMD_REG_REL_TIME   8'hB3
`define CMD_REG_REL_VEL    8'hA1
`define FRAME_WORDS        4'h9
`define ACC_TIME_MAX       32'h0000FFFE
`define TOTAL_TIME_MIN     32'h00000002
`define ACCEL_MIN          32'h00000001
`define ACCEL_MAX          32'h3FFFFFFF
`define SIGNED_MAX         32'h7FFFFFFF
`define RAMP_TIME_MAX      32'h0000FFFE
`define REG_LATENCY        2'h1
`endif

// File: hdl/reg_move_pkg.sv
// Types for the register-based move command decoder
package reg_move_pkg;
  typedef enum logic [1:0] {
    prof_abs_time,
    prof_abs_vel,
    prof_rel_time,
    prof_rel_vel
  } profile_t;
endpackage

// File: hdl/frame_bus_if.sv
// Word stream between the frame assembler and the decoder
`timescale 1ns/10ps
interface frame_bus_if;
  logic        word_valid;
  logic [15:0] word;
  logic        frame_end;
  modport source (output word_valid, output word, output frame_end);
  modport sink   (input word_valid, input word, input frame_end);
endinterface

// File: hdl/frame_word_gate.sv
// Registers incoming 16-bit command words and marks frame ends
`timescale 1ns/10ps
module frame_word_gate
(
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    reset,
  // Raw words from the serial receiver
  input  wire logic        in_valid,
  input  wire logic [15:0] in_word,
  input  wire logic        in_end,
  // Registered stream
  frame_bus_if.source      out
);
  logic        valid_reg;
  logic [15:0] word_reg;
  logic        end_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      valid_reg <= 1'b0;
      word_reg  <= 16'h0000;
      end_reg   <= 1'b0;
    end
    else
    begin
      valid_reg <= in_valid;
      word_reg  <= in_word;
      end_reg   <= in_valid & in_end;
    end
  end

  assign out.word_valid = valid_reg;
  assign out.word       = word_reg;
  assign out.frame_end  = end_reg;
endmodule // frame_word_gate

// File: hdl/register_move_command_decoder.sv
// Decoder for the four register-sourced point-to-point move commands
// How it works
// - Absolute time move: code 178, nine words
// - Absolute velocity move: code 160, nine words
// - Relative time move: code 179, same order
// - Relative velocity move: code 161, same order
// - Absolute: target position read from register
// - Relative: distance from register plus present position
// - Absolute time variant starts ordinary time profile
// - Absolute velocity variant starts ordinary velocity profile
// - Relative velocity variant starts ordinary relative velocity profile
// - Stop enable and state end motion; zero disables
`timescale 1ns/10ps
`include "reg_move_map.svh"
module register_move_command_decoder
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Command words from the serial link, one 16-bit word per strobe
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  input  wire logic        cmd_last,
  // User data register file read port, one cycle latency
  output logic [7:0]       ureg_addr,
  output logic             ureg_rd,
  input  wire logic [31:0] ureg_data,
  // Present position from the motion engine
  input  wire logic [31:0] present_pos,
  // Profile start to the basic move engines
  output logic             move_start,
  output reg_move_pkg::profile_t move_kind,
  output logic [31:0]      move_target,
  output logic [31:0]      move_param_a,
  output logic [31:0]      move_param_b,
  output logic             stop_en_valid,
  output logic [15:0]      stop_enable,
  output logic [15:0]      stop_state,
  // Answer to the host
  output logic             ack,
  output logic             nak
);
  // ----------------------------------------------------------------
  // Word stream
  // ----------------------------------------------------------------
  frame_bus_if fb ();

  frame_word_gate u_gate
  (
    .clk      (clk),
    .reset    (reset),
    .in_valid (cmd_valid),
    .in_word  (cmd_word),
    .in_end   (cmd_last),
    .out      (fb.source)
  );

  // ----------------------------------------------------------------
  // Frame collection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {st_collect, st_fetch, st_wait, st_issue} state_t;

  state_t            state_reg;
  logic [3:0]        count_reg;
  logic [15:0]       words_reg [0:8];
  logic              start_reg;
  reg_move_pkg::profile_t kind_reg;
  logic [31:0]       target_reg;
  logic [31:0]       pa_reg;
  logic [31:0]       pb_reg;
  logic              sv_reg;
  logic [15:0]       se_reg;
  logic [15:0]       ss_reg;
  logic              ack_reg;
  logic              nak_reg;
  logic              rd_reg;
  logic [7:0]        addr_reg;

  // ----------------------------------------------------------------
  // Command decode and parameter checks
  // ----------------------------------------------------------------
  wire [7:0]  code       = words_reg[0][7:0];
  wire [31:0] data_reg_w = {words_reg[1], words_reg[2]};
  wire [31:0] param_a_w  = {words_reg[3], words_reg[4]};
  wire [31:0] param_b_w  = {words_reg[5], words_reg[6]};
  wire        is_abs_time = code == `CMD_REG_ABS_TIME;
  wire        is_abs_vel  = code == `CMD_REG_ABS_VEL;
  wire        is_rel_time = code == `CMD_REG_REL_TIME;
  wire        is_rel_vel  = code == `CMD_REG_REL_VEL;
  wire        is_time    = is_abs_time | is_rel_time;
  wire        is_vel     = is_abs_vel | is_rel_vel;
  wire        is_rel     = is_rel_time | is_rel_vel;
  wire        known      = is_time | is_vel;
  wire        count_ok   = count_reg == `FRAME_WORDS;
  // Parameter checks; the device refuses what the sender must avoid
  wire        time_ok    = param_a_w <= `ACC_TIME_MAX &&
                           param_b_w >= `TOTAL_TIME_MIN &&
                           param_b_w <= `SIGNED_MAX;
  wire        vel_ok     = param_a_w >= `ACCEL_MIN &&
                           param_a_w <= `ACCEL_MAX &&
                           param_b_w <= `SIGNED_MAX;
  // Velocity over acceleration bound expressed in time units
  wire [63:0] ramp_prod  = 64'(param_a_w) * 64'(`RAMP_TIME_MAX);
  wire        ratio_ok   = {32'h00000000, param_b_w} < ramp_prod;
  wire        params_ok  = is_time ? time_ok : (vel_ok & ratio_ok);
  wire        frame_ok   = known & count_ok & params_ok &
                           (data_reg_w[31:8] == 24'h000000);
  wire [3:0]  count_inc  = count_reg + 4'h1;
  wire        frame_done = fb.word_valid & fb.frame_end;
  wire [31:0] target_w   = is_rel ? ureg_data + present_pos
                                  : ureg_data;
  reg_move_pkg::profile_t kind_w;
  assign kind_w = is_abs_time ? reg_move_pkg::prof_abs_time :
                  is_abs_vel  ? reg_move_pkg::prof_abs_vel  :
                  is_rel_time ? reg_move_pkg::prof_rel_time :
                                reg_move_pkg::prof_rel_vel;

  // ----------------------------------------------------------------
  // Word store
  // ----------------------------------------------------------------
  // Words past the ninth are dropped; the count still runs to refuse them
  always_ff @(posedge clk)
  begin
    if (fb.word_valid && state_reg == st_collect &&
        count_reg < `FRAME_WORDS)
      words_reg[count_reg] <= fb.word;
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= st_collect;
      count_reg <= 4'h0;
      start_reg <= 1'b0;
      ack_reg   <= 1'b0;
      nak_reg   <= 1'b0;
      rd_reg    <= 1'b0;
      addr_reg  <= 8'h00;
      kind_reg  <= reg_move_pkg::prof_abs_time;
      target_reg <= 32'h00000000;
      pa_reg    <= 32'h00000000;
      pb_reg    <= 32'h00000000;
      sv_reg    <= 1'b0;
      se_reg    <= 16'h0000;
      ss_reg    <= 16'h0000;
    end
    else
    begin
      start_reg <= 1'b0;
      ack_reg   <= 1'b0;
      nak_reg   <= 1'b0;
      rd_reg    <= 1'b0;
      case (state_reg)
        st_collect:
        begin
          if (fb.word_valid)
          begin
            if (count_reg < 4'hF)
              count_reg <= count_inc;
            if (frame_done)
              state_reg <= st_fetch;
          end
        end
        st_fetch:
        begin
          count_reg <= 4'h0;
          if (frame_ok)
          begin
            addr_reg  <= data_reg_w[7:0];
            rd_reg    <= 1'b1;
            state_reg <= st_wait;
          end
          else
          begin
            nak_reg   <= 1'b1;
            state_reg <= st_collect;
          end
        end
        // Read data arrives one cycle after the read pulse
        st_wait:
          state_reg <= st_issue;
        st_issue:
        begin
          target_reg <= target_w;
          kind_reg   <= kind_w;
          pa_reg     <= param_a_w;
          pb_reg     <= param_b_w;
          se_reg     <= words_reg[7];
          ss_reg     <= words_reg[8];
          sv_reg     <= words_reg[7] != 16'h0000;
          start_reg  <= 1'b1;
          ack_reg    <= 1'b1;
          state_reg  <= st_collect;
        end
        default:
          state_reg <= st_collect;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output comes straight from a register
  assign ureg_addr     = addr_reg;
  assign ureg_rd       = rd_reg;
  assign move_start    = start_reg;
  assign move_kind     = kind_reg;
  assign move_target   = target_reg;
  assign move_param_a  = pa_reg;
  assign move_param_b  = pb_reg;
  assign stop_en_valid = sv_reg;
  assign stop_enable   = se_reg;
  assign stop_state    = ss_reg;
  assign ack           = ack_reg;
  assign nak           = nak_reg;
endmodule // register_move_command_decoder

// File: dv/move_assertions.sv
// Port checker for the register move decoder
`timescale 1ns/10ps
module move_assertions
(
  // Ports of the decoder
  input wire logic                   clk,
  input wire logic                   reset,
  input wire logic                   cmd_valid,
  input wire logic [15:0]            cmd_word,
  input wire logic                   cmd_last,
  input wire logic [7:0]             ureg_addr,
  input wire logic                   ureg_rd,
  input wire logic [31:0]            ureg_data,
  input wire logic [31:0]            present_pos,
  input wire logic                   move_start,
  input wire reg_move_pkg::profile_t move_kind,
  input wire logic [31:0]            move_target,
  input wire logic [31:0]            move_param_a,
  input wire logic [31:0]            move_param_b,
  input wire logic                   stop_en_valid,
  input wire logic [15:0]            stop_enable,
  input wire logic [15:0]            stop_state,
  input wire logic                   ack,
  input wire logic                   nak
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire logic is_rel = move_kind[1];
  sequence s_fetch; ureg_rd ##2 move_start; endsequence
  a_answer_time:
    assert property (cmd_valid && cmd_last |-> ##3 (ureg_rd || nak))
    else $error("no answer");
  a_read_to_ack:
    assert property (ureg_rd |-> ##2 ack) else $error("ack late");
  a_start_acked:
    assert property (move_start |-> ack && !nak) else $error("bad ack");
  a_nak_pulse:
    assert property (nak |=> !nak && !move_start) else $error("nak long");
  a_abs_target:
    assert property (s_fetch ##0 !is_rel |-> move_target == $past(ureg_data))
    else $error("abs target");
  a_rel_target:
    assert property (s_fetch ##0 is_rel |->
      move_target == $past(ureg_data) + $past(present_pos))
    else $error("rel target");
  a_stop_flag:
    assert property (move_start |-> stop_en_valid == (stop_enable != 16'h0))
    else $error("stop flag");
  a_params_hold:
    assert property (!move_start && !$past(reset) |-> $stable(move_param_a)
      && $stable(move_param_b)) else $error("params moved");
endmodule // move_assertions
bind register_move_command_decoder move_assertions chk (.clk, .reset,
  .cmd_valid, .cmd_word, .cmd_last, .ureg_addr, .ureg_rd, .ureg_data,
  .present_pos, .move_start, .move_kind, .move_target, .move_param_a,
  .move_param_b, .stop_en_valid, .stop_enable, .stop_state, .ack, .nak);

// File: dv/user_reg_model.sv
// User data register file answering the decoder's reads
`timescale 1ns/10ps
module user_reg_model
(
  // Read port
  input wire logic        clk,
  input wire logic [7:0]  ureg_addr,
  input wire logic        ureg_rd,
  input wire logic        move_start,
  output logic     [31:0] ureg_data
);
  initial ureg_data = 32'h0;
  // Held until the start, then scrambled so stale data never matches
  always @(posedge clk)
    if (ureg_rd)
      ureg_data <= {ureg_addr, 8'h5A, ~ureg_addr, ureg_addr};
    else if (move_start)
      ureg_data <= ~ureg_data;
endmodule // user_reg_model

// File: dv/register_move_command_decoder_tb.sv
// Random and corner frames through the register move decoder
`timescale 1ns/10ps
module register_move_command_decoder_tb;
  logic clk = 1'h0, reset = 1'h1, cmd_valid = 1'h0, cmd_last = 1'h0;
  logic [15:0] cmd_word = 16'h0, stop_enable, stop_state;
  logic [31:0] present_pos = 32'h0, ureg_data, move_target, rnd = 32'h5B08;
  logic [31:0] move_param_a, move_param_b;
  logic [7:0]  ureg_addr;
  logic        ureg_rd, move_start, stop_en_valid, ack, nak;
  reg_move_pkg::profile_t move_kind;
  int num_errors = 0, checks = 0, cyc = 0;
  always #50 clk = ~clk;
  register_move_command_decoder dut (.clk, .reset, .cmd_valid, .cmd_word,
    .cmd_last, .ureg_addr, .ureg_rd, .ureg_data, .present_pos, .move_start,
    .move_kind, .move_target, .move_param_a, .move_param_b, .stop_en_valid,
    .stop_enable, .stop_state, .ack, .nak);
  user_reg_model partner (.clk, .ureg_addr, .ureg_rd, .move_start, .ureg_data);
  function automatic logic [31:0] next_rand();
    rnd = {rnd[30:0], 1'h0} ^ (rnd[31] ? 32'h04C11DB7 : 32'h0);
    return rnd;
  endfunction
  function automatic bit legal(logic [7:0] c, logic [31:0] r, a, b);
    return r <= 32'hFF && (c[7:1] == 7'h59 ? a <= 32'hFFFE && b >= 32'h2
      && b <= 32'h7FFFFFFF : c[7:1] == 7'h50 && a >= 32'h1 && a <= 32'h3FFFFFFF
      && b <= 32'h7FFFFFFF && 64'(b) < 64'(a) * 64'hFFFE);
  endfunction
  task automatic cmp(input string nm, input logic [63:0] e, g);
    checks++;
    num_errors += int'(g !== e);
    if (g !== e) $display("MISMATCH %s exp %h got %h", nm, e, g);
  endtask
  task automatic run(logic [7:0] c, logic [31:0] r, a, b, logic [15:0] se,
    ss, int n);
    logic [15:0] w [9];
    logic [31:0] tgt;
    bit          ok;
    w = '{{8'h00, c}, r[31:16], r[15:0], a[31:16], a[15:0], b[31:16],
      b[15:0], se, ss};
    ok = legal(c, r, a, b) && n == 9;
    present_pos <= next_rand();
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      cmd_valid <= 1'h1;
      cmd_word <= w[i];
      cmd_last <= (i == n - 1);
    end
    @(posedge clk);
    cmd_valid <= 1'h0;
    cmd_last <= 1'h0;
    tgt = {r[7:0], 8'h5A, ~r[7:0], r[7:0]} + (c[0] ? present_pos : 32'h0);
    for (int t = 0; t < 20 && ack !== 1'h1 && nak !== 1'h1; t++)
      @(posedge clk) #1;
    cmp("answer", {ok, ok, !ok}, {ack, move_start, nak});
    if (ok)
    begin
      cmp("kind_target", {c[0], ~c[4], tgt},
        {move_kind, move_target});
      cmp("params", {a, b}, {move_param_a, move_param_b});
      cmp("stop", {se != 16'h0, se, ss},
        {stop_en_valid, stop_enable, stop_state});
    end
    @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
    if (++cyc == 5000)
    begin
      num_errors++;
      tally_and_finish();
    end
  initial
  begin
    logic [31:0] r, s;
    logic [7:0]  c;
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    run(8'hB2, 32'h0, 32'hFFFE, 32'h2, 16'h0, 16'h0, 9);
    run(8'hB3, 32'hFF, 32'hFFFF, 32'h9, 16'h1, 16'h1, 9);
    run(8'hA1, 32'h100, 32'h1, 32'h1, 16'h0, 16'h0, 9);
    run(8'hA0, 32'h7, 32'h0, 32'h0, 16'h0, 16'h0, 9);
    run(8'hA1, 32'h7, 32'h1, 32'hFFFE, 16'h0, 16'h0, 9);
    run(8'h5D, 32'h7, 32'h1, 32'h1, 16'h0, 16'h0, 9);
    run(8'hA0, 32'h7, 32'h1, 32'h5, 16'h3, 16'h1, 8);
    for (int k = 0; k < 60; k++)
    begin
      r = next_rand();
      s = next_rand();
      c = r[1] ? {4'hA, 3'h0, r[0]} : {4'hB, 3'h1, r[0]};
      run(c, {24'h0, r[15:8]}, c[4] ? {16'h0, s[15:0]} : {2'h0, s[29:0]},
        {1'h0, r[30:16], s[31:16]}, r[31:16] & {16{r[2]}}, s[31:16],
        9);
    end
    tally_and_finish();
  end
endmodule // register_move_command_decoder_tb
